// ---- shared/lacc_defines.svh ----
/*
  Constants for the locality access and error control block: access register field
  positions, reset values, locality count, buffer size and self-test timing.
  Assumes a 25 MHz core clock.
*/
`ifndef LACC_DEFINES_SVH
`define LACC_DEFINES_SVH

// ----------------------------------------------------------------------------
// Access register fields
// ----------------------------------------------------------------------------
`define LACC_BIT_ESTABLISHMENT  0
`define LACC_BIT_REQUEST_USE    1
`define LACC_BIT_PENDING        2
`define LACC_BIT_SEIZE          3
`define LACC_BIT_SEIZED         4
`define LACC_BIT_ACTIVE         5
`define LACC_BIT_RESERVED       6
`define LACC_BIT_VALID          7
`define LACC_SHUTDOWN_READ      8'hff
`define LACC_RESET_VALUE        8'h01

// ----------------------------------------------------------------------------
// Sizes and timing
// ----------------------------------------------------------------------------
`define LACC_NUM_LOCALITIES     5
`define LACC_HASH_LOCALITY      4
`define LACC_MIN_INPUT_BYTES    1101
`define LACC_CLK_HZ             25000000
`define LACC_SELF_TEST_MS       1000
`define LACC_SELF_TEST_CYCLES   ((`LACC_CLK_HZ / 1000) * `LACC_SELF_TEST_MS)
`define LACC_VALID_DELAY        2

`endif

// ---- shared/lacc_pkg.sv ----
/*
  Types for the locality access and error control block.
  Assumes lacc_defines.svh is available on the include path.
*/
`default_nettype none
package lacc_pkg;
  // Register access from the host bus front end
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] locality;
    logic [7:0] wdata;
  } lacc_access_type;

  // Read answer towards the host bus front end
  typedef struct packed {
    logic       done;
    logic       long_wait;
    logic       abort;
    logic [7:0] rdata;
  } lacc_answer_type;

  // Error mode of the module
  typedef enum logic [1:0] {LACC_WORKING, LACC_FAILURE, LACC_SHUTDOWN} lacc_mode_type;
endpackage
`default_nettype wire

// ---- rtl/lacc_self_test.sv ----
/*
  Self-test sequencer: runs the deferred self-test after the continue command,
  and never starts on early boot queries such as the timeout capability.
  Assumes a single core clock; commands arrive as one-cycle pulses.
*/
`include "lacc_defines.svh"
`default_nettype none
module lacc_self_test #(
  parameter int unsigned TEST_CYCLES = `LACC_SELF_TEST_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic continue_i,
  input  wire logic timeout_query_i,
  input  wire logic fail_inject_i,
  output logic      busy_o,
  output logic      done_o,
  output logic      failed_o
);
  initial begin
    if (TEST_CYCLES < 1) $error("TEST_CYCLES must be at least 1");
  end

  logic [31:0] count;
  wire         start_test = continue_i & ~busy_o & ~done_o;

  // ----------------------------------------------------------------------------
  // Test timer
  // ----------------------------------------------------------------------------
  // Capability queries do not touch the timer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      count    <= 32'h0;
      busy_o   <= 1'b0;
      done_o   <= 1'b0;
      failed_o <= 1'b0;
    end else if (start_test) begin
      busy_o <= 1'b1;
      count  <= 32'h0;
    end else if (busy_o) begin
      if (fail_inject_i) failed_o <= 1'b1;
      if (count == 32'(TEST_CYCLES - 1)) begin
        busy_o <= 1'b0;
        done_o <= 1'b1;
      end else begin
        count <= count + 32'h1;
      end
    end
  end
endmodule  // lacc_self_test
`default_nettype wire

// ---- rtl/lacc_access.sv ----
/*
  Locality access register bank with error modes (working, failure, shutdown),
  command input byte counter and self-test sequencing.
  Assumes a host bus front end that presents one-cycle access strobes with the
  locality decoded, and that resetn_i is driven by the hardware init signal.
  Attack and error inputs come from pins and are synchronised here.
*/
`include "lacc_defines.svh"
`default_nettype none
module lacc_access #(
  parameter int unsigned NUM_LOC     = `LACC_NUM_LOCALITIES,
  parameter int unsigned INPUT_BYTES = `LACC_MIN_INPUT_BYTES,
  parameter int unsigned TEST_CYCLES = `LACC_SELF_TEST_CYCLES
) (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  input  wire lacc_pkg::lacc_access_type access_i,
  input  wire logic                   established_i,
  input  wire logic                   attack_i,
  input  wire logic                   error_i,
  input  wire logic                   cmd_byte_i,
  input  wire logic                   cmd_start_i,
  input  wire logic                   hash_cmd_i,
  input  wire logic                   continue_test_i,
  input  wire logic                   timeout_query_i,
  output lacc_pkg::lacc_answer_type   answer_o,
  output logic [2:0]                  active_loc_o,
  output logic                        loc_active_o,
  output logic                        hash_accept_o,
  output logic                        cmd_overflow_o,
  output logic                        failure_mode_o,
  output logic                        shutdown_o,
  output logic                        self_test_done_o
);
  initial begin
    if (NUM_LOC < 1 || NUM_LOC > 8) $error("NUM_LOC must be 1 to 8");
    if (INPUT_BYTES < `LACC_MIN_INPUT_BYTES) $error("INPUT_BYTES below minimum");
  end

  // ----------------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] attack_sync;
  logic [1:0] error_sync;
  logic [1:0] est_sync;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      attack_sync <= 2'h0;
      error_sync  <= 2'h0;
      est_sync    <= 2'h0;
    end else begin
      attack_sync <= {attack_sync[0], attack_i};
      error_sync  <= {error_sync[0], error_i};
      est_sync    <= {est_sync[0], established_i};
    end
  end
  wire attack_s = attack_sync[1];
  wire error_s  = error_sync[1];

  // ----------------------------------------------------------------------------
  // Error mode
  // ----------------------------------------------------------------------------
  lacc_pkg::lacc_mode_type mode;
  lacc_pkg::lacc_mode_type next_mode;
  logic test_failed;
  always_comb begin
    next_mode = mode;
    unique case (mode)
      lacc_pkg::LACC_WORKING: begin
        if (attack_s) next_mode = lacc_pkg::LACC_SHUTDOWN;
        else if (error_s | test_failed) next_mode = lacc_pkg::LACC_FAILURE;
      end
      lacc_pkg::LACC_FAILURE: begin
        if (attack_s) next_mode = lacc_pkg::LACC_SHUTDOWN;
      end
      lacc_pkg::LACC_SHUTDOWN: next_mode = lacc_pkg::LACC_SHUTDOWN;  // held until init
      default: next_mode = lacc_pkg::LACC_SHUTDOWN;
    endcase
  end
  // Init clears shutdown; a persisting attack re-enters it via the sync chain
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) mode <= lacc_pkg::LACC_WORKING;
    else mode <= next_mode;
  end
  wire in_shutdown = (mode == lacc_pkg::LACC_SHUTDOWN);

  // ----------------------------------------------------------------------------
  // Valid settle timer after init
  // ----------------------------------------------------------------------------
  logic [1:0] settle;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) settle <= 2'h0;
    else if (settle != 2'(`LACC_VALID_DELAY)) settle <= settle + 2'h1;
  end
  wire regs_valid = (settle == 2'(`LACC_VALID_DELAY)) & ~in_shutdown;

  // ----------------------------------------------------------------------------
  // Access write decode
  // ----------------------------------------------------------------------------
  logic [NUM_LOC-1:0] request;
  logic [NUM_LOC-1:0] seized;
  logic [2:0]         owner;
  logic               owned;

  wire [2:0] loc     = access_i.locality;
  wire       wr_ok   = access_i.wr & ~in_shutdown & (32'(loc) < NUM_LOC);
  // Zero fields do nothing; priority when several are set: seize, release, request
  wire       w_seize = wr_ok & access_i.wdata[`LACC_BIT_SEIZE];
  wire       w_rel   = wr_ok & access_i.wdata[`LACC_BIT_ACTIVE] & ~w_seize;
  wire       w_req   = wr_ok & access_i.wdata[`LACC_BIT_REQUEST_USE] & ~w_seize & ~w_rel;
  wire       w_clrsz = wr_ok & access_i.wdata[`LACC_BIT_SEIZED];
  wire       is_own  = owned & (owner == loc);
  wire       do_rel  = w_rel & is_own;
  wire       do_seize = w_seize & owned & (loc > owner);

  // Highest set bit of a request vector
  function automatic logic [3:0] lacc_highest(input logic [NUM_LOC-1:0] v);
    lacc_highest = 4'h0;
    for (int i = 0; i < NUM_LOC; i++) begin
      if (v[i]) lacc_highest = {1'b1, 3'(i)};
    end
  endfunction

  logic [NUM_LOC-1:0] next_request;
  always_comb begin
    next_request = request;
    if (w_req & ~is_own) next_request[loc] = 1'b1;
    if (w_rel & ~is_own) next_request[loc] = 1'b0;  // cancel pending
  end
  wire [3:0] pick = lacc_highest(next_request);

  // ----------------------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------------------
  wire grant_free = ~owned & pick[3];
  wire grant_rel  = do_rel & pick[3];
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      owned   <= 1'b0;
      owner   <= 3'h0;
      request <= '0;
    end else begin
      request <= next_request;
      if (do_seize | (w_seize & ~owned)) begin
        owned <= 1'b1;
        owner <= loc;
        request[loc] <= 1'b0;
      end else if (grant_free | grant_rel) begin
        owned <= 1'b1;
        owner <= pick[2:0];
        request[pick[2:0]] <= 1'b0;
      end else if (do_rel) begin
        owned <= 1'b0;
      end
    end
  end

  // Seized flags: set wins over clear
  genvar g;
  generate
    for (g = 0; g < NUM_LOC; g++) begin : g_seized
      always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) seized[g] <= 1'b0;
        else if (do_seize & (owner == 3'(g))) seized[g] <= 1'b1;
        else if (w_clrsz & (loc == 3'(g))) seized[g] <= 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------------------
  // Read data and answer
  // ----------------------------------------------------------------------------
  // A waited read keeps the locality of its strobe
  logic       rd_wait;
  logic [2:0] rd_loc;
  wire  [2:0] rloc   = rd_wait ? rd_loc : loc;
  wire        loc_ok = 32'(rloc) < NUM_LOC;
  wire        r_own  = owned & (owner == rloc);
  wire [7:0] rd_word = {regs_valid, 1'b0,
                        r_own,
                        loc_ok & seized[rloc],
                        1'b0,
                        |(request & ~(loc_ok ? (NUM_LOC'(1) << rloc) : '0)),
                        loc_ok & request[rloc],
                        ~est_sync[1]};
  wire  rd_go = (access_i.rd | rd_wait);
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      answer_o <= '0;
      rd_wait  <= 1'b0;
      rd_loc   <= 3'h0;
    end else if (in_shutdown) begin
      answer_o <= {access_i.rd | access_i.wr, 1'b0, access_i.rd | access_i.wr,
                   `LACC_SHUTDOWN_READ};
      rd_wait  <= 1'b0;
    end else if (rd_go & ~regs_valid) begin
      answer_o <= {1'b0, 1'b1, 1'b0, 8'h00};
      rd_wait  <= 1'b1;
      rd_loc   <= rloc;
    end else begin
      answer_o <= {rd_go | access_i.wr, 1'b0, 1'b0, rd_go ? rd_word : 8'h00};
      rd_wait  <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------------
  // Command input counter and hash path
  // ----------------------------------------------------------------------------
  logic [15:0] byte_count;
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      byte_count     <= 16'h0;
      cmd_overflow_o <= 1'b0;
      hash_accept_o  <= 1'b0;
    end else begin
      hash_accept_o <= hash_cmd_i & ~owned & ~in_shutdown;
      if (cmd_start_i) begin
        byte_count     <= 16'h0;
        cmd_overflow_o <= 1'b0;
      end else if (cmd_byte_i) begin
        if (byte_count == 16'(INPUT_BYTES)) cmd_overflow_o <= 1'b1;
        else byte_count <= byte_count + 16'h1;
      end
    end
  end

  // ----------------------------------------------------------------------------
  // Self test and status outputs
  // ----------------------------------------------------------------------------
  logic test_done;
  lacc_self_test #(.TEST_CYCLES(TEST_CYCLES)) u_self_test (
    .clk_i           (clk_i),
    .resetn_i        (resetn_i),
    .continue_i      (continue_test_i & ~in_shutdown),
    .timeout_query_i (timeout_query_i),
    .fail_inject_i   (error_s),
    .busy_o          (),
    .done_o          (test_done),
    .failed_o        (test_failed)
  );
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      active_loc_o     <= 3'h0;
      loc_active_o     <= 1'b0;
      failure_mode_o   <= 1'b0;
      shutdown_o       <= 1'b0;
      self_test_done_o <= 1'b0;
    end else begin
      active_loc_o     <= owner;
      loc_active_o     <= owned;
      failure_mode_o   <= (mode == lacc_pkg::LACC_FAILURE);
      shutdown_o       <= in_shutdown;
      self_test_done_o <= test_done;
    end
  end
endmodule  // lacc_access
`default_nettype wire

// ---- tb/lacc_checker.sv ----
/* Checker: port relations of the locality access block.
   Assumes it is bound to lacc_access by the bench top file. */
`default_nettype none
module lacc_checker (
  input wire logic                      clk_i,
  input wire logic                      resetn_i,
  input wire lacc_pkg::lacc_access_type access_i,
  input wire logic                      established_i,
  input wire logic                      attack_i,
  input wire logic                      hash_cmd_i,
  input wire lacc_pkg::lacc_answer_type answer_o,
  input wire logic [2:0]                active_loc_o,
  input wire logic                      loc_active_o,
  input wire logic                      hash_accept_o,
  input wire logic                      shutdown_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic ok_rd = answer_o.done && !answer_o.abort;

  a_shut_abort: assert property (shutdown_o && (access_i.rd || access_i.wr)
    |=> answer_o.done && answer_o.abort && answer_o.rdata == 8'hff)
    else $error("shutdown access not aborted");
  a_attack_shut: assert property (attack_i [*4] |-> ##[0:3] shutdown_o)
    else $error("attack did not shut down");
  a_shut_stays: assert property (shutdown_o |=> shutdown_o)
    else $error("shutdown left without init");
  a_read_answer: assert property (access_i.rd && !shutdown_o
    |=> answer_o.done || answer_o.long_wait) else $error("read not answered");
  a_valid_fixed: assert property (ok_rd && $past(access_i.rd)
    |-> answer_o.rdata[7] && !answer_o.rdata[6] && !answer_o.rdata[3])
    else $error("read done without valid flag");
  a_est_inverse: assert property (ok_rd && $past(access_i.rd) && $stable(established_i)
    && established_i == $past(established_i, 4) |-> answer_o.rdata[0] == !established_i)
    else $error("establishment not inverted");
  a_owner_only: assert property (ok_rd && $past(access_i.rd) && answer_o.rdata[5]
    |-> loc_active_o && active_loc_o == $past(access_i.locality))
    else $error("active field at non owner");
  a_free_grant: assert property (access_i.wr && access_i.wdata == 8'h02
    && access_i.locality < 3'h5 && !loc_active_o && !shutdown_o
    |-> ##2 loc_active_o && active_loc_o == $past(access_i.locality, 2))
    else $error("free request not granted");
  a_hash_free: assert property (hash_cmd_i && !loc_active_o && !shutdown_o
    |=> hash_accept_o) else $error("hash command refused");
  c_abort: cover property (shutdown_o && answer_o.abort);
  c_hash: cover property (hash_accept_o);
  c_release: cover property ($fell(loc_active_o));
endmodule // lacc_checker
`default_nettype wire

// ---- tb/lacc_host_model.sv ----
/* Host model: software at the localities, one register access at a time.
   Assumes the bench calls xfer and that the block answers after the take edge. */
`default_nettype none
module lacc_host_model (
  input  wire logic                      clk_i,
  input  wire lacc_pkg::lacc_answer_type answer_i,
  output lacc_pkg::lacc_access_type      access_o,
  output logic                           timeout_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------------------------------------------------
  // Access driver
  // --------------------------------------------------------------------------
  initial access_o = '{rd: 1'b0, wr: 1'b0, locality: 3'h0, wdata: 8'h00};
  initial timeout_o = 1'b0;
  // Strobe one cycle, then wait a bounded time for the answer
  task automatic xfer(input logic r, input logic [2:0] loc, input logic [7:0] d,
                      output lacc_pkg::lacc_answer_type ans);
    @(negedge clk_i);
    access_o = '{rd: r, wr: !r, locality: loc, wdata: d};
    @(negedge clk_i);
    access_o = '{rd: 1'b0, wr: 1'b0, locality: ~loc, wdata: ~d};
    ans = answer_i;
    for (int n = 0; n < 50 && ans.done !== 1'b1; n++) begin
      @(negedge clk_i);
      ans = answer_i;
    end
    if (ans.done !== 1'b1) timeout_o = 1'b1;
  endtask
endmodule // lacc_host_model
`default_nettype wire

// ---- tb/locality_access_error_control_test.sv ----
/* Bench top: drives the access block through its host model and pins.
   Assumes the package, header and design files are compiled first. */
`default_nettype none
module locality_access_error_control_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0, resetn_i = 1'b0, est = 1'b0, attack = 1'b0, err = 1'b0;
  logic cbyte = 1'b0, cstart = 1'b0, hash = 1'b0, cont = 1'b0, tq = 1'b0;
  logic [2:0]                active_loc;
  logic                      loc_act, hash_ok, ovf, fail_m, shut, st_done, tmo;
  lacc_pkg::lacc_access_type acc;
  lacc_pkg::lacc_answer_type answer, ans;
  int                        error_cnt = 0, cmp_count = 0, cyc = 0;

  always #20 clk_i = ~clk_i;
  lacc_host_model lacc_host_model_i (.clk_i(clk_i), .answer_i(answer), .access_o(acc),
    .timeout_o(tmo));
  lacc_access #(.TEST_CYCLES(20)) lacc_access_i (.clk_i(clk_i), .resetn_i(resetn_i),
    .access_i(acc), .established_i(est), .attack_i(attack), .error_i(err),
    .cmd_byte_i(cbyte), .cmd_start_i(cstart), .hash_cmd_i(hash), .continue_test_i(cont),
    .timeout_query_i(tq), .answer_o(answer), .active_loc_o(active_loc),
    .loc_active_o(loc_act), .hash_accept_o(hash_ok), .cmd_overflow_o(ovf),
    .failure_mode_o(fail_m), .shutdown_o(shut), .self_test_done_o(st_done));
  // --------------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    if (error_cnt == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic wr(input logic [2:0] loc, input logic [7:0] d);
    lacc_host_model_i.xfer(1'b0, loc, d, ans);
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [2:0] loc, input logic [7:0] exp);
    lacc_host_model_i.xfer(1'b1, loc, 8'h00, ans);
    chk(ans.rdata, exp);
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_arbitrate();
    rd(3'h0, 8'h81);
    wr(3'h1, 8'h02);
    rd(3'h1, 8'ha1);
    wr(3'h0, 8'h02);
    rd(3'h0, 8'h83);
    wr(3'h3, 8'h02);
    wr(3'h1, 8'h00);
    rd(3'h1, 8'ha5);
    wr(3'h1, 8'h20);
    chk({5'h00, active_loc}, 8'h03);
    wr(3'h3, 8'h20);
    chk({5'h00, active_loc}, 8'h00);
    chk({7'h00, loc_act}, 8'h01);
    wr(3'h0, 8'h20);
    chk({7'h00, loc_act}, 8'h00);
  endtask
  task automatic t_seize();
    wr(3'h0, 8'h02);
    wr(3'h2, 8'h08);
    chk({5'h00, active_loc}, 8'h02);
    rd(3'h0, 8'h91);
    wr(3'h0, 8'h10);
    rd(3'h0, 8'h81);
    wr(3'h2, 8'h20);
  endtask
  task automatic t_hash_est();
    pulse(hash);
    chk({7'h00, hash_ok}, 8'h01);
    est = 1'b1;
    repeat (4) @(negedge clk_i);
    rd(3'h0, 8'h80);
    est = 1'b0;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic t_failure();
    err = 1'b1;
    repeat (4) @(negedge clk_i);
    chk({7'h00, fail_m}, 8'h01);
    wr(3'h4, 8'h02);
    rd(3'h4, 8'ha1);
    wr(3'h4, 8'h20);
    chk({7'h00, loc_act}, 8'h00);
    err = 1'b0;
  endtask
  task automatic t_buffer();
    pulse(cstart);
    repeat (1101) pulse(cbyte);
    chk({7'h00, ovf}, 8'h00);
    pulse(cbyte);
    @(negedge clk_i);
    chk({7'h00, ovf}, 8'h01);
  endtask
  task automatic t_selftest();
    pulse(tq);
    repeat (30) @(negedge clk_i);
    chk({7'h00, st_done}, 8'h00);
    pulse(cont);
    for (int n = 0; n < 40 && st_done !== 1'b1; n++) @(negedge clk_i);
    chk({7'h00, st_done}, 8'h01);
  endtask
  task automatic t_shutdown();
    attack = 1'b1;
    repeat (6) @(negedge clk_i);
    chk({7'h00, shut}, 8'h01);
    rd(3'h2, 8'hff);
    chk({7'h00, ans.abort}, 8'h01);
    wr(3'h2, 8'h02);
    chk({7'h00, loc_act}, 8'h00);
    do_reset();
    repeat (4) @(negedge clk_i);
    chk({7'h00, shut}, 8'h01);
    attack = 1'b0;
    do_reset();
    chk({7'h00, shut}, 8'h00);
    rd(3'h0, 8'h81);
  endtask
  // Read right after init stalls until the valid flag settles
  task automatic t_settle();
    @(negedge clk_i);
    resetn_i = 1'b0;
    repeat (5) @(negedge clk_i);
    resetn_i = 1'b1;
    fork
      lacc_host_model_i.xfer(1'b1, 3'h2, 8'h00, ans);
      begin
        repeat (2) @(negedge clk_i);
        chk({7'h00, answer.long_wait}, 8'h01);
      end
    join
    chk(ans.rdata, 8'h81);
  endtask
  // Cycle ceiling against a hang
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000 || tmo === 1'b1) begin
      error_cnt++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    do_reset();
    t_arbitrate();
    t_seize();
    t_hash_est();
    t_failure();
    t_buffer();
    t_selftest();
    t_shutdown();
    t_settle();
    final_report();
  end
endmodule // locality_access_error_control_test
bind lacc_access lacc_checker lacc_checker_i (.clk_i(clk_i), .resetn_i(resetn_i),
  .access_i(access_i), .established_i(established_i), .attack_i(attack_i),
  .hash_cmd_i(hash_cmd_i), .answer_o(answer_o), .active_loc_o(active_loc_o),
  .loc_active_o(loc_active_o), .hash_accept_o(hash_accept_o), .shutdown_o(shutdown_o));
`default_nettype wire
